// ---- verilog/ee_pkg.sv ----
`default_nettype none
package ee_pkg;
  // ==========================================
  // timing
  localparam int CLK_HZ    = 100_000_000;
  localparam int CLK_NS    = 10;
  localparam int T_RST_MS  = 200;
  localparam int T_WR_MS   = 10;
  localparam int T_QTR_NS  = 2500;
  localparam int RST_CYC   = T_RST_MS * (CLK_HZ / 1000);
  localparam int WR_CYC    = T_WR_MS * (CLK_HZ / 1000);
  localparam int QTR_CYC   = T_QTR_NS / CLK_NS;
  localparam int CNT_W     = 25;
  localparam int QTR_W     = 9;
  // ==========================================
  // memory shape and address byte
  localparam int ADDR_W    = 11;
  localparam int PAGE_W    = 4;
  localparam int MEM_DEPTH = 2048;
  localparam int PAGE_LEN  = 16;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  // ==========================================
  // master bit phases and commands, device transfer states
  localparam logic [1:0] Q_SET  = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_MID  = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WR, OP_RD} op_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WORD, ST_WDAT,
                            ST_RD} dev_st_t;
endpackage
`default_nettype wire

// ---- verilog/twi_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// two-wire bus: scl from master, open-drain sda
interface twi_if;
  logic scl;       // serial clock, master driven
  logic sda_m_oe;  // master pulls sda low
  logic sda_d_oe;  // device pulls sda low
  logic sda;       // resolved wired-and level
  assign sda = !(sda_m_oe | sda_d_oe);
  modport master (output scl, output sda_m_oe, input sda);
  modport dev    (input scl, output sda_d_oe, input sda);
endinterface // twi_if
`default_nettype wire

// ---- verilog/eeprom_dev.sv ----
`timescale 1ns/100ps
`default_nettype none
module eeprom_dev #(
  parameter int RST_CYCLES = ee_pkg::RST_CYC,
  parameter int WR_CYCLES  = ee_pkg::WR_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  twi_if.dev        bus,
  input  wire logic wp,
  input  wire logic rsthi_i,
  output logic      rsthi_o,
  output logic      rsthi_oe,
  input  wire logic rstlo_n_i,
  output logic      rstlo_n_o,
  output logic      rstlo_n_oe,
  output logic      busy
);
  import ee_pkg::*;

  // ==========================================
  // state
  logic                scl_q_r;     // last scl sample
  logic                sda_q_r;     // last sda sample
  dev_st_t             state_r;     // transfer phase
  logic [3:0]          cnt_r;       // bits seen in byte
  logic                ack_ph_r;    // inside ninth clock
  logic [7:0]          sr_r;        // receive shifter
  logic [7:0]          tx_r;        // transmit shifter
  logic                oe_r;        // sda pull low
  logic [ADDR_W-1:0]   ptr_r;       // address counter
  logic [2:0]          hi_r;        // high address bits
  logic                dir_r;       // one means read
  logic                mack_r;      // master acked
  logic [PAGE_LEN-1:0] pval_r;      // loaded page slots
  logic [7:0]          pbuf [PAGE_LEN];  // page buffer
  logic [7:0]          mem [MEM_DEPTH];  // array
  logic                busy_r;      // write cycle runs
  logic [CNT_W-1:0]    wcnt_r;      // write cycle count
  logic                rhi_q_r;     // last high pin
  logic                rlo_q_r;     // last low pin
  logic                run_r;       // reset pulse runs
  logic [CNT_W-1:0]    rcnt_r;      // reset pulse count
  logic                drv_hi_r;    // drive high pin
  logic                drv_lo_r;    // drive low pin

  logic                scl_hi;      // scl high twice
  logic                start_c;     // start seen
  logic                stop_c;      // stop seen
  logic                rise_c;      // scl rising
  logic                fall_c;      // scl falling
  logic                wr_done;     // last write cycle
  logic                rst_act;     // any reset held
  logic [7:0]          rd_byte;     // byte at counter
  logic [PAGE_W-1:0]   slot;        // write step slot

  // ==========================================
  // bus conditions
  assign scl_hi  = bus.scl & scl_q_r;
  assign start_c = scl_hi & sda_q_r & !bus.sda;
  assign stop_c  = scl_hi & !sda_q_r & bus.sda;
  assign rise_c  = bus.scl & !scl_q_r;
  assign fall_c  = !bus.scl & scl_q_r;
  assign rd_byte = mem[ptr_r];
  assign slot    = wcnt_r[PAGE_W-1:0];
  assign wr_done = busy_r && (wcnt_r == CNT_W'(WR_CYCLES - 1));
  // held pins or a running pulse lock the memory out
  assign rst_act = run_r | rsthi_i | !rstlo_n_i;

  // pin samples for edge finding
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= bus.scl;
      sda_q_r <= bus.sda;
    end
  end

  // ==========================================
  // protocol engine
  // any sda change with scl high resets framing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      ack_ph_r <= 1'b0;
      sr_r     <= '0;
      tx_r     <= '0;
      oe_r     <= 1'b0;
      ptr_r    <= '0;
      hi_r     <= '0;
      dir_r    <= 1'b0;
      mack_r   <= 1'b0;
      pval_r   <= '0;
    end else begin
      // page slots empty once programmed
      if (wr_done) begin
        pval_r <= '0;
      end
      if (start_c) begin
        // framing restarts on any start
        state_r  <= ST_DEV;
        cnt_r    <= '0;
        ack_ph_r <= 1'b0;
        oe_r     <= 1'b0;
      end else if (stop_c) begin
        state_r  <= ST_IDLE;
        ack_ph_r <= 1'b0;
        oe_r     <= 1'b0;
      end else if (state_r == ST_IDLE) begin
        // ignore everything until a start
        oe_r <= 1'b0;
      end else if (rise_c) begin
        if (!ack_ph_r) begin
          // data bit sampled on rising scl
          cnt_r <= cnt_r + 4'h1;
          sr_r  <= {sr_r[6:0], bus.sda};
        end else begin
          // ninth clock: master ack when reading
          mack_r <= !bus.sda;
        end
      end else if (fall_c) begin
        if (ack_ph_r) begin
          // end of ninth clock: release and move on
          ack_ph_r <= 1'b0;
          cnt_r    <= '0;
          oe_r     <= 1'b0;
          case (state_r)
            ST_DEV: begin
              if (dir_r) begin
                // current address read
                state_r <= ST_RD;
                tx_r    <= rd_byte;
                oe_r    <= !rd_byte[7];
                ptr_r   <= ptr_r + 1'b1;
              end else begin
                state_r <= ST_WORD;
              end
            end
            ST_WORD: begin
              state_r <= ST_WDAT;
            end
            ST_RD: begin
              if (mack_r) begin
                // next byte, whole counter wraps
                tx_r  <= rd_byte;
                oe_r  <= !rd_byte[7];
                ptr_r <= ptr_r + 1'b1;
              end else begin
                state_r <= ST_IDLE;
              end
            end
            default: begin
            end
          endcase
        end else if (cnt_r == BIT_ACK) begin
          // eighth bit done: decide the ninth clock
          case (state_r)
            ST_DEV: begin
              if (sr_r[7:4] == DEV_TYPE && !busy_r
                  && !rst_act) begin
                ack_ph_r <= 1'b1;
                oe_r     <= 1'b1;
                hi_r     <= sr_r[3:1];
                dir_r    <= sr_r[0];
              end else begin
                state_r <= ST_IDLE;
              end
            end
            ST_WORD: begin
              ack_ph_r <= 1'b1;
              oe_r     <= 1'b1;
              ptr_r    <= {hi_r, sr_r};
            end
            ST_WDAT: begin
              if (wp || rst_act) begin
                // protected: refuse, nothing stored
                state_r <= ST_IDLE;
              end else begin
                ack_ph_r     <= 1'b1;
                oe_r         <= 1'b1;
                pbuf[ptr_r[PAGE_W-1:0]]   <= sr_r;
                pval_r[ptr_r[PAGE_W-1:0]] <= 1'b1;
                ptr_r <= {ptr_r[ADDR_W-1:PAGE_W],
                          ptr_r[PAGE_W-1:0] + 1'b1};
              end
            end
            ST_RD: begin
              // let the master answer
              ack_ph_r <= 1'b1;
              oe_r     <= 1'b0;
            end
            default: begin
              state_r <= ST_IDLE;
            end
          endcase
        end else if (state_r == ST_RD && cnt_r != '0) begin
          // next data bit out on falling scl
          tx_r <= {tx_r[6:0], 1'b0};
          oe_r <= !tx_r[6];
        end
      end
    end
  end

  // ==========================================
  // internal write cycle
  // timed from our own clock, started by stop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      wcnt_r <= '0;
    end else if (!busy_r && stop_c && state_r == ST_WDAT
                 && |pval_r) begin
      busy_r <= 1'b1;
      wcnt_r <= '0;
    end else if (busy_r) begin
      wcnt_r <= wcnt_r + 1'b1;
      if (wr_done) begin
        busy_r <= 1'b0;
      end
    end
  end

  // programs one page slot per clock at cycle start
  always_ff @(posedge clk) begin
    if (busy_r && wcnt_r < CNT_W'(PAGE_LEN) && pval_r[slot]) begin
      mem[{ptr_r[ADDR_W-1:PAGE_W], slot}] <= pbuf[slot];
    end
  end

  // ==========================================
  // manual reset pulse
  // history starts at active level: no edge at release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rhi_q_r  <= 1'b1;
      rlo_q_r  <= 1'b0;
      run_r    <= 1'b0;
      rcnt_r   <= '0;
      drv_hi_r <= 1'b0;
      drv_lo_r <= 1'b0;
    end else begin
      rhi_q_r <= rsthi_i;
      rlo_q_r <= rstlo_n_i;
      if (!run_r && ((rsthi_i && !rhi_q_r)
                     || (!rstlo_n_i && rlo_q_r))) begin
        // only the active edge starts the pulse
        run_r    <= 1'b1;
        rcnt_r   <= '0;
        drv_lo_r <= rsthi_i && !rhi_q_r;
        drv_hi_r <= !rstlo_n_i && rlo_q_r;
      end else if (run_r) begin
        rcnt_r <= rcnt_r + 1'b1;
        if (rcnt_r == CNT_W'(RST_CYCLES - 1)) begin
          // ends even if the input stays active
          run_r    <= 1'b0;
          drv_hi_r <= 1'b0;
          drv_lo_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // outputs
  assign bus.sda_d_oe = oe_r;
  assign rsthi_o      = 1'b1;
  assign rsthi_oe     = drv_hi_r;
  assign rstlo_n_o    = 1'b0;
  assign rstlo_n_oe   = drv_lo_r;
  assign busy         = busy_r;

endmodule // eeprom_dev
`default_nettype wire

// ---- verilog/twi_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module twi_master (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  twi_if.master            bus,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire ee_pkg::op_t cmd_op,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_ack,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_nack
);
  import ee_pkg::*;

  // ==========================================
  // state
  logic             run_r;    // command in progress
  op_t              op_r;     // current command
  logic [7:0]       tx_r;     // write shifter
  logic [7:0]       rx_r;     // read shifter
  logic             acko_r;   // ack to send on read
  logic [1:0]       q_r;      // quarter of bit
  logic [3:0]       bidx_r;   // bit index
  logic [QTR_W-1:0] tick_r;   // quarter timer
  logic             scl_r;    // scl level
  logic             oe_r;     // sda pull low
  logic             rv_r;     // answer strobe
  logic [7:0]       rd_r;     // answer data
  logic             nk_r;     // answer nack
  logic             tick;     // quarter elapsed
  logic             last;     // final bit of command

  assign tick = tick_r == QTR_W'(QTR_CYC - 1);
  assign last = (op_r == OP_START || op_r == OP_STOP) ?
                (bidx_r == '0) : (bidx_r == BIT_ACK);

  // quarter timer runs only during a command
  always_ff @(posedge clk) begin
    if (sys_rst || !run_r || tick) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 1'b1;
    end
  end

  // ==========================================
  // bit sequencer
  // data moves sda in the scl-low quarter; start and stop move it at Q_MID with scl high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_r  <= 1'b0;
      op_r   <= OP_STOP;
      tx_r   <= '0;
      rx_r   <= '0;
      acko_r <= 1'b0;
      q_r    <= Q_SET;
      bidx_r <= '0;
      scl_r  <= 1'b1;
      oe_r   <= 1'b0;
      rv_r   <= 1'b0;
      rd_r   <= '0;
      nk_r   <= 1'b0;
    end else begin
      rv_r <= 1'b0;
      if (!run_r && cmd_valid) begin
        run_r  <= 1'b1;
        op_r   <= cmd_op;
        tx_r   <= cmd_data;
        acko_r <= cmd_ack;
        q_r    <= Q_SET;
        bidx_r <= '0;
      end else if (run_r && tick) begin
        q_r <= q_r + 1'b1;
        case (q_r)
          Q_SET: begin
            case (op_r)
              OP_START: oe_r <= 1'b0;
              OP_STOP:  oe_r <= 1'b1;
              OP_WR:    oe_r <= (bidx_r != BIT_ACK) && !tx_r[7];
              default:  oe_r <= (bidx_r == BIT_ACK) && acko_r;
            endcase
          end
          Q_RISE: begin
            scl_r <= 1'b1;
          end
          Q_MID: begin
            case (op_r)
              OP_START: oe_r <= 1'b1;
              OP_STOP:  oe_r <= 1'b0;
              OP_WR: begin
                if (bidx_r == BIT_ACK) begin
                  nk_r <= bus.sda;
                end
              end
              default: begin
                if (bidx_r != BIT_ACK) begin
                  rx_r <= {rx_r[6:0], bus.sda};
                end
              end
            endcase
          end
          default: begin
            if (op_r != OP_STOP) begin
              scl_r <= 1'b0;
            end
            tx_r <= {tx_r[6:0], 1'b0};
            if (last) begin
              run_r <= 1'b0;
              rv_r  <= 1'b1;
              rd_r  <= rx_r;
            end else begin
              bidx_r <= bidx_r + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // ==========================================
  // outputs
  assign bus.scl      = scl_r;
  assign bus.sda_m_oe = oe_r;
  assign cmd_ready    = !run_r;
  assign rsp_valid    = rv_r;
  assign rsp_data     = rd_r;
  assign rsp_nack     = nk_r;

endmodule // twi_master
`default_nettype wire

// ---- testbench/ee_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bus and reset-pin checker beside the wires
module ee_chk #(
  parameter int RST_CYCLES = 200,
  parameter int WR_CYCLES  = 12000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_m_oe,
  input wire logic sda_d_oe,
  input wire logic sda,
  input wire logic busy,
  input wire logic rsthi_i,
  input wire logic rsthi_oe,
  input wire logic rstlo_n_i,
  input wire logic rstlo_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [24:0] busy_cnt_r;  // cycles busy has stood
  logic [24:0] pls_cnt_r;   // cycles the low pin pulse has stood
  // ==========================================
  // length counters for busy and the low pin pulse
  always_ff @(posedge clk) begin
    busy_cnt_r <= (sys_rst || !busy) ? 25'h000_0000 : busy_cnt_r + 25'h1;
  end
  always_ff @(posedge clk) begin
    pls_cnt_r <= (sys_rst || !rstlo_n_oe) ? 25'h000_0000 : pls_cnt_r + 25'h1;
  end
  // ==========================================
  // wire-level properties
  a_dev_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device moved sda with scl high");
  a_scl_high_len: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  a_busy_quiet: assert property (busy |-> !sda_d_oe)
    else $error("device drove sda while programming");
  a_busy_after_stop: assert property ($rose(busy) |-> scl && sda)
    else $error("programming began without a stop");
  a_busy_len: assert property ($fell(busy) |->
      busy_cnt_r >= WR_CYCLES - 1 && busy_cnt_r <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  a_pulse_len: assert property ($fell(rstlo_n_oe) |->
      pls_cnt_r >= RST_CYCLES - 1 && pls_cnt_r <= RST_CYCLES + 1)
    else $error("reset pulse length wrong");
  a_hi_edge_pulse: assert property ($rose(rsthi_i) && !rsthi_oe
      && !rstlo_n_oe |-> ##[1:2] rstlo_n_oe)
    else $error("high pin edge gave no pulse");
  a_lo_edge_pulse: assert property ($fell(rstlo_n_i) && !rstlo_n_oe
      && !rsthi_oe |-> ##[1:2] rsthi_oe)
    else $error("low pin edge gave no pulse");
  a_pulse_cause: assert property ($rose(rstlo_n_oe) |->
      $past(rsthi_i) && !$past(rsthi_i, 2))
    else $error("reset pulse without an edge");
  // master moves sda with scl high only for start or stop
  a_move_released: assert property ($changed(sda_m_oe) && scl |->
      !sda_d_oe)
    else $error("start or stop while device held sda");
endmodule // ee_chk
`default_nettype wire

// ---- testbench/tb_i2c_eeprom_slave_with_reset_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// master and device joined on one bus
module tb_i2c_eeprom_slave_with_reset_gate;
  import ee_pkg::*;
  localparam int RSTC = 200;    // shortened reset pulse
  localparam int WRC  = 12000;  // outlasts one polled address byte
  logic       clk;          // system clock
  logic       sys_rst;      // sync reset
  logic       wp;           // write protect pin
  logic       ext_hi;       // outside party forcing high pin
  logic       ext_lo;       // outside party pulling low pin
  logic       cmd_valid;    // master command request
  logic       cmd_ready;    // master idle
  op_t        cmd_op;       // command kind
  logic [7:0] cmd_data;     // byte to send
  logic       cmd_ack;      // ack a read byte
  logic       rsp_valid;    // command done
  logic [7:0] rsp_data;     // byte read
  logic       rsp_nack;     // slave withheld ack
  logic       rsthi_o;      // unused drive level
  logic       rsthi_oe;     // device drives high pin
  logic       rstlo_n_o;    // unused drive level
  logic       rstlo_n_oe;   // device drives low pin
  logic       busy;         // programming in progress
  wire logic  rsthi_i;      // resolved high pin, pulldown
  wire logic  rstlo_n_i;    // resolved low pin, pull-up
  int         n_errors;     // mismatches
  int         checks_done;  // comparisons
  int         cyc;          // timeout counter
  assign rsthi_i   = rsthi_oe | ext_hi;
  assign rstlo_n_i = !(rstlo_n_oe | ext_lo);
  twi_if twi ();
  twi_master twi_master_i (.clk(clk), .sys_rst(sys_rst), .bus(twi.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  eeprom_dev #(.RST_CYCLES(RSTC), .WR_CYCLES(WRC)) eeprom_dev_i (
    .clk(clk), .sys_rst(sys_rst), .bus(twi.dev), .wp(wp),
    .rsthi_i(rsthi_i), .rsthi_o(rsthi_o), .rsthi_oe(rsthi_oe),
    .rstlo_n_i(rstlo_n_i), .rstlo_n_o(rstlo_n_o),
    .rstlo_n_oe(rstlo_n_oe), .busy(busy));
  ee_chk #(.RST_CYCLES(RSTC), .WR_CYCLES(WRC)) ee_chk_i (.clk(clk),
    .sys_rst(sys_rst), .scl(twi.scl), .sda_m_oe(twi.sda_m_oe),
    .sda_d_oe(twi.sda_d_oe), .sda(twi.sda), .busy(busy),
    .rsthi_i(rsthi_i), .rsthi_oe(rsthi_oe), .rstlo_n_i(rstlo_n_i),
    .rstlo_n_oe(rstlo_n_oe));
  // ==========================================
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end
  // ==========================================
  // shared helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one master command, entered just after an edge
  task automatic op(input op_t o, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    cmd_op = o;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 10000) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    check({7'h00, rsp_valid}, 8'h01);
  endtask
  // ==========================================
  // byte write to 0x5a3, then busy must stand
  task automatic t_byte_write();
    op(OP_START, 8'h00, 1'b0);
    op(OP_WR, 8'haa, 1'b0);
    check({7'h00, rsp_nack}, 8'h00);
    op(OP_WR, 8'ha3, 1'b0);
    check({7'h00, rsp_nack}, 8'h00);
    op(OP_WR, 8'h3c, 1'b0);
    check({7'h00, rsp_nack}, 8'h00);
    op(OP_STOP, 8'h00, 1'b0);
    check({7'h00, busy}, 8'h01);
  endtask
  // address poll during programming is refused
  task automatic t_poll();
    int n;
    n = 0;
    op(OP_START, 8'h00, 1'b0);
    op(OP_WR, 8'haa, 1'b0);
    check({7'h00, rsp_nack}, 8'h01);
    op(OP_STOP, 8'h00, 1'b0);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    check({7'h00, busy}, 8'h00);
  endtask
  // random read of 0x5a3 with high bits from the address byte
  task automatic t_random_read();
    op(OP_START, 8'h00, 1'b0);
    op(OP_WR, 8'haa, 1'b0);
    check({7'h00, rsp_nack}, 8'h00);
    op(OP_WR, 8'ha3, 1'b0);
    check({7'h00, rsp_nack}, 8'h00);
    op(OP_START, 8'h00, 1'b0);
    op(OP_WR, 8'hab, 1'b0);
    check({7'h00, rsp_nack}, 8'h00);
    op(OP_RD, 8'h00, 1'b0);
    check(rsp_data, 8'h3c);
    op(OP_STOP, 8'h00, 1'b0);
  endtask
  // held manual reset: pulse ends anyway, then low pin edge
  task automatic t_manual_reset();
    // let the pin history leave its reset level first
    @(posedge clk);
    #1 ext_hi = 1'b1;
    repeat (3) @(posedge clk);
    #1 check({7'h00, rstlo_n_oe}, 8'h01);
    repeat (RSTC + 4) @(posedge clk);
    #1 check({7'h00, rstlo_n_oe}, 8'h00);
    // pin still held past the pulse: memory stays locked out
    op(OP_START, 8'h00, 1'b0);
    op(OP_WR, 8'haa, 1'b0);
    check({7'h00, rsp_nack}, 8'h01);
    op(OP_STOP, 8'h00, 1'b0);
    ext_hi = 1'b0;
    ext_lo = 1'b1;
    repeat (3) @(posedge clk);
    #1 check({7'h00, rsthi_oe}, 8'h01);
    ext_lo = 1'b0;
    repeat (RSTC + 4) @(posedge clk);
    #1 check({7'h00, rsthi_oe}, 8'h00);
  endtask
  // ==========================================
  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    wp = 1'b0;
    ext_hi = 1'b0;
    ext_lo = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_manual_reset();
    t_byte_write();
    t_poll();
    t_random_read();
    close_out();
  end
endmodule // tb_i2c_eeprom_slave_with_reset_gate
`default_nettype wire
